// [bench/jtag_host_model.sv]
// behavioural board-level boundary-scan controller driving the test port pins
// assumes the caller starts a scan from run-test-idle and waits between calls
`timescale 1ns/1ps
module jtag_host_model (
    output logic tck_out,
    output logic tms_out,
    output logic tms_oe_n_out,
    output logic tdi_out,
    output logic tdi_oe_n_out,
    input wire logic tdo_line_in
);
    // ========================================================
    // pin defaults: test clock parked low between frames
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tms_oe_n_out = 1'b0;
        tdi_out = 1'b1;
        tdi_oe_n_out = 1'b0;
    end
    // ========================================================
    // one period, 240 ns low then 160 ns high; tdo taken just before the rise
    task automatic pulse(output logic q);
        #240;
        q = tdo_line_in;
        tck_out = 1'b1;
        #160;
        tck_out = 1'b0;
    endtask
    // new mode and data bits change with the falling edge
    task automatic step(input logic m, input logic d, output logic q);
        tms_out = m;
        tdi_out = d;
        pulse(q);
    endtask
    // wiggle mode and data with the clock parked; nothing may move
    task automatic wiggle(input int n);
        repeat (n) begin
            #70;
            tms_out = ~tms_out;
            tdi_out = ~tdi_out;
        end
        tms_out = 1'b0;
    endtask
    // full scan from idle: select, capture, shift n bits, update, idle
    task automatic scan(input logic is_ir, input logic [127:0] din, input int n,
                        input int hold, output logic [127:0] dout);
        logic q;
        dout = 128'h0;
        step(1'b1, 1'b1, q);
        if (is_ir) begin
            step(1'b1, 1'b1, q);
        end
        step(1'b0, 1'b1, q);
        step(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            if (i == n / 2 && hold > 0) begin
                wiggle(hold);
            end
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask
    // one driven high, then four with the pin released at the inverse level
    task automatic float_reset();
        logic q;
        step(1'b1, 1'b1, q);
        tms_oe_n_out = 1'b1;
        tms_out = 1'b0;
        repeat (4) pulse(q);
        tms_oe_n_out = 1'b0;
        step(1'b0, 1'b1, q);
    endtask
endmodule

// [bench/test_sram_tap.sv]
// self-checking bench for the sram test access port
// assumes the host model owns the test pins and the bench owns clock and reset
`timescale 1ns/1ps
module test_sram_tap;
    localparam int BITS = tap_pkg::BSR_LEN;
    localparam logic [108:0] CAP_PAT = 109'h1234_5678_9abc_def0_1357_9bdf_2468;
    localparam logic [108:0] PRE_PAT = 109'h0f0f_0f0f_0f0f_0f0f_0f0f_0f0f_0f0f;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic [BITS-1:0] pins_cap = '0;
    logic tck, tms, tms_oe_n, tdi, tdi_oe_n, tdo, tdo_oe_n, extest, q_bus_en;
    logic [BITS-1:0] pins_drive;
    logic [127:0] dout;
    logic [2:0] prev;
    int num_errors = 0;
    int cmp_count = 0;
    bit done = 1'b0;
    // tdo has no pull, so a released pin is plain high impedance
    wire tdo_line = tdo_oe_n ? 1'bz : tdo;
    // ========================================================
    // design and far-side controller
    sram_tap #(.BSR_BITS(BITS)) u_dut (.core_clk_in(core_clk), .sys_rst_in(sys_rst),
        .clk_en_in(clk_en), .tck_in(tck), .tms_in(tms), .tms_oe_n_in(tms_oe_n),
        .tdi_in(tdi), .tdi_oe_n_in(tdi_oe_n), .pins_capture_in(pins_cap),
        .tdo_out(tdo), .tdo_oe_n_out(tdo_oe_n), .pins_drive_out(pins_drive),
        .extest_out(extest), .q_bus_en_out(q_bus_en));
    jtag_host_model u_host (.tck_out(tck), .tms_out(tms), .tms_oe_n_out(tms_oe_n),
        .tdi_out(tdi), .tdi_oe_n_out(tdi_oe_n), .tdo_line_in(tdo_line));
    always #25 core_clk = ~core_clk;
    // ========================================================
    // shared helpers
    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // outputs lag the pins by the synchroniser, so let them land first
    task automatic settle();
        repeat (8) @(negedge core_clk);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ========================================================
    // scenarios
    task automatic t_power();
        check("tdo_oe_n", 128'(tdo_oe_n), 128'h1);
        check("q_bus_en", 128'(q_bus_en), 128'h1);
        check("extest", 128'(extest), 128'h0);
        check("oe cell", 128'(pins_drive[tap_pkg::OE_CELL]), 128'h1);
        $display("test power done");
    endtask
    // idcode shifted with a long parked-clock pause in the middle
    task automatic t_idcode();
        u_host.scan(1'b0, 128'hffff_ffff, 32, 30, dout);
        settle();
        check("idcode", 128'(dout[31:0]), 128'(tap_pkg::ID_CODE));
        check("idle tdo_oe_n", 128'(tdo_oe_n), 128'h1);
        check("q_bus_en", 128'(q_bus_en), 128'h1);
        $display("test idcode done");
    endtask
    // clock enable low swallows a whole test-clock pulse; the controller must not move
    task automatic t_freeze();
        logic q;
        @(negedge core_clk);
        clk_en = 1'b0;
        u_host.step(1'b1, 1'b1, q);
        @(negedge core_clk);
        clk_en = 1'b1;
        settle();
        check("frozen tdo_oe_n", 128'(tdo_oe_n), 128'h1);
        u_host.scan(1'b0, 128'h0, 32, 0, dout);
        check("frozen idcode", 128'(dout[31:0]), 128'(tap_pkg::ID_CODE));
        $display("test freeze done");
    endtask
    // bypass and every reserved code, each with an ir capture check
    task automatic t_bypass();
        logic [2:0] ops [4] = '{tap_pkg::OP_BYPASS, 3'h3, 3'h5, 3'h6};
        prev = tap_pkg::OP_IDCODE;
        foreach (ops[k]) begin
            u_host.scan(1'b1, 128'(ops[k]), 3, 0, dout);
            check("ir low", 128'(dout[1:0]), 128'(tap_pkg::IR_CAPTURE));
            check("ir high", 128'(dout[2]), 128'(prev[2]));
            u_host.scan(1'b0, 128'h96, 8, 0, dout);
            check("bypass", 128'(dout[7:0]), 128'h2c);
            prev = ops[k];
        end
        $display("test bypass done");
    endtask
    // sample, preload, external test, sample-z, then a floating-pin reset
    task automatic t_boundary();
        @(negedge core_clk);
        pins_cap = CAP_PAT;
        u_host.scan(1'b1, 128'(tap_pkg::OP_SAMPLE), 3, 0, dout);
        u_host.scan(1'b0, 128'(PRE_PAT), BITS, 0, dout);
        settle();
        check("capture", 128'(dout[108:0]), 128'(CAP_PAT));
        check("preload", 128'(pins_drive), 128'(PRE_PAT));
        check("sample q_bus_en", 128'(q_bus_en), 128'h1);
        u_host.scan(1'b1, 128'(tap_pkg::OP_EXTEST), 3, 0, dout);
        settle();
        check("extest", 128'(extest), 128'h1);
        check("extest q_bus_en", 128'(q_bus_en), 128'h0);
        u_host.scan(1'b1, 128'(tap_pkg::OP_SAMPLE_Z), 3, 0, dout);
        settle();
        check("samplez q_bus_en", 128'(q_bus_en), 128'h0);
        u_host.float_reset();
        settle();
        check("reset extest", 128'(extest), 128'h0);
        check("reset q_bus_en", 128'(q_bus_en), 128'h1);
        check("reset oe cell", 128'(pins_drive[tap_pkg::OE_CELL]), 128'h1);
        u_host.scan(1'b0, 128'h0, 32, 0, dout);
        check("reset idcode", 128'(dout[31:0]), 128'(tap_pkg::ID_CODE));
        $display("test boundary done");
    endtask
    // ========================================================
    // main sequence and hang guard
    initial begin
        logic q;
        repeat (5) @(negedge core_clk);
        sys_rst = 1'b0;
        settle();
        t_power();
        u_host.step(1'b0, 1'b1, q);
        t_idcode();
        t_freeze();
        t_bypass();
        t_boundary();
        done = 1'b1;
        end_of_test();
    end
    initial begin
        for (int i = 0; i < 90000 && !done; i++) begin
            @(posedge core_clk);
        end
        if (!done) begin
            num_errors++;
            end_of_test();
        end
    end
endmodule

// [hdl/sram_tap.sv]
// boundary-scan test access port of the burst sram
// assumes test clock far slower than core_clk_in; pins pass two flops first
// Operation
// - full standard controller, instruction and data register behaviour
// - test clock held low means no state changes, memory untouched
// - floating mode select and serial input read as high
// - after power-up sits in reset without disturbing memory
// - sample inputs on test-clock rise, change serial output on fall
// - held instruction picks the shift register on the serial path
// - at most one register on the serial path at once
// - shift in at most significant end, out from least significant bit
// - serial output driven only in shift states, else high impedance
// - five high mode-select rises enter test-logic reset
// - test reset leaves memory operation undisturbed
// - power-up reset keeps serial output high impedance
// - three-bit instruction register shifts only when selected
// - identification instruction loaded at power-up and in reset
// - capture-instruction loads 01 into the two low bits
// - single-bit bypass register, captured as zero
// - identification register captures fixed 32-bit code, shifts it out
// - instructions shift in shift-ir, take effect at update-ir
// - cell 108 enables data outputs under external test, presets high
`timescale 1ns/1ps
module sram_tap #(
    parameter int BSR_BITS = tap_pkg::BSR_LEN
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tms_oe_n_in,
    input wire logic tdi_in,
    input wire logic tdi_oe_n_in,
    input wire logic [BSR_BITS-1:0] pins_capture_in,
    output logic tdo_out,
    output logic tdo_oe_n_out,
    output logic [BSR_BITS-1:0] pins_drive_out,
    output logic extest_out,
    output logic q_bus_en_out
);
    // the output enable cell must sit inside the chain
    if (BSR_BITS <= tap_pkg::OE_CELL) begin : g_chain_short
        $error("boundary chain too short");
    end

    // ========================================================
    // input sampling
    logic tck_rise;
    logic tck_fall;
    logic [1:0] tms_s;
    logic [1:0] tdi_s;
    logic tms_v;
    logic tdi_v;

    tck_sync u_tck (
        .clk_in(core_clk_in),
        .rst_in(sys_rst_in),
        .en_in(clk_en_in),
        .async_in(tck_in),
        .level_out(),
        .rise_out(tck_rise),
        .fall_out(tck_fall)
    );

    // floating pins read high, the internal pull-up
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            tms_s <= 2'h3;
            tdi_s <= 2'h3;
        end else if (clk_en_in) begin
            tms_s <= {tms_s[0], tms_oe_n_in | tms_in};
            tdi_s <= {tdi_s[0], tdi_oe_n_in | tdi_in};
        end
    end
    assign tms_v = tms_s[1];
    assign tdi_v = tdi_s[1];

    // ========================================================
    // controller
    tap_pkg::tap_state_t state;
    tap_pkg::tap_state_t next_state;
    logic [2:0] ones_run;
    logic [2:0] next_ones_run;

    // transitions only on a test-clock rise; a stopped clock freezes all
    always_comb begin
        next_state = state;
        next_ones_run = ones_run;
        if (tck_rise) begin
            // run of high mode-select rises, saturating, only watched by the check
            if (!tms_v) next_ones_run = 3'h0;
            else if (ones_run != 3'(tap_pkg::RESET_ONES)) next_ones_run = ones_run + 3'h1;
            unique case (state)
                tap_pkg::ST_RESET: next_state = tms_v ? tap_pkg::ST_RESET : tap_pkg::ST_IDLE;
                tap_pkg::ST_IDLE: next_state = tms_v ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
                tap_pkg::ST_SEL_DR: next_state = tms_v ? tap_pkg::ST_SEL_IR : tap_pkg::ST_CAP_DR;
                tap_pkg::ST_CAP_DR: next_state = tms_v ? tap_pkg::ST_EX1_DR : tap_pkg::ST_SH_DR;
                tap_pkg::ST_SH_DR: next_state = tms_v ? tap_pkg::ST_EX1_DR : tap_pkg::ST_SH_DR;
                tap_pkg::ST_EX1_DR: next_state = tms_v ? tap_pkg::ST_UPD_DR : tap_pkg::ST_PAU_DR;
                tap_pkg::ST_PAU_DR: next_state = tms_v ? tap_pkg::ST_EX2_DR : tap_pkg::ST_PAU_DR;
                tap_pkg::ST_EX2_DR: next_state = tms_v ? tap_pkg::ST_UPD_DR : tap_pkg::ST_SH_DR;
                tap_pkg::ST_UPD_DR: next_state = tms_v ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
                tap_pkg::ST_SEL_IR: next_state = tms_v ? tap_pkg::ST_RESET : tap_pkg::ST_CAP_IR;
                tap_pkg::ST_CAP_IR: next_state = tms_v ? tap_pkg::ST_EX1_IR : tap_pkg::ST_SH_IR;
                tap_pkg::ST_SH_IR: next_state = tms_v ? tap_pkg::ST_EX1_IR : tap_pkg::ST_SH_IR;
                tap_pkg::ST_EX1_IR: next_state = tms_v ? tap_pkg::ST_UPD_IR : tap_pkg::ST_PAU_IR;
                tap_pkg::ST_PAU_IR: next_state = tms_v ? tap_pkg::ST_EX2_IR : tap_pkg::ST_PAU_IR;
                tap_pkg::ST_EX2_IR: next_state = tms_v ? tap_pkg::ST_UPD_IR : tap_pkg::ST_SH_IR;
                tap_pkg::ST_UPD_IR: next_state = tms_v ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
            endcase
        end
    end

    // reset state after power-up, memory side untouched
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            state <= tap_pkg::ST_RESET;
            ones_run <= 3'h0;
        end else if (clk_en_in) begin
            state <= next_state;
            ones_run <= next_ones_run;
        end
    end

    // ========================================================
    // instruction and data registers
    logic [2:0] ir_shift;
    logic [2:0] ir;
    logic bypass;
    logic [31:0] id_shift;
    logic [BSR_BITS-1:0] bsr_shift;
    logic [BSR_BITS-1:0] bsr_hold;
    logic [2:0] next_ir_shift;
    logic [2:0] next_ir;
    logic next_bypass;
    logic [31:0] next_id_shift;
    logic [BSR_BITS-1:0] next_bsr_shift;
    logic [BSR_BITS-1:0] next_bsr_hold;
    logic sel_ir;
    logic sel_bsr;
    logic sel_id;
    logic serial_bit;

    // reserved codes fall to bypass
    function automatic logic [1:0] dr_sel(input logic [2:0] op);
        unique case (op)
            tap_pkg::OP_IDCODE: dr_sel = 2'h1;
            tap_pkg::OP_EXTEST, tap_pkg::OP_SAMPLE_Z, tap_pkg::OP_SAMPLE: dr_sel = 2'h2;
            default: dr_sel = 2'h0;
        endcase
    endfunction

    always_comb begin
        sel_ir = (state == tap_pkg::ST_SH_IR);
        sel_bsr = (dr_sel(ir) == 2'h2);
        sel_id = (dr_sel(ir) == 2'h1);
        next_ir_shift = ir_shift;
        next_ir = ir;
        next_bypass = bypass;
        next_id_shift = id_shift;
        next_bsr_shift = bsr_shift;
        next_bsr_hold = bsr_hold;
        if (tck_rise) begin
            unique case (state)
                // fixed 01 in the low bits checks the path
                tap_pkg::ST_CAP_IR: next_ir_shift = {ir[2], tap_pkg::IR_CAPTURE};
                // shift only while selected, new bit at the top
                tap_pkg::ST_SH_IR: next_ir_shift = {tdi_v, ir_shift[2:1]};
                tap_pkg::ST_UPD_IR: next_ir = ir_shift;
                tap_pkg::ST_CAP_DR: begin
                    next_bypass = 1'b0;
                    if (sel_id) next_id_shift = tap_pkg::ID_CODE;
                    if (sel_bsr) next_bsr_shift = pins_capture_in;
                end
                tap_pkg::ST_SH_DR: begin
                    if (sel_bsr) next_bsr_shift = {tdi_v, bsr_shift[BSR_BITS-1:1]};
                    else if (sel_id) next_id_shift = {tdi_v, id_shift[31:1]};
                    else next_bypass = tdi_v;
                end
                tap_pkg::ST_UPD_DR: if (sel_bsr) next_bsr_hold = bsr_shift;
                default: ;
            endcase
        end
        // test-logic reset restores the id instruction and the oe cell
        if (state == tap_pkg::ST_RESET) begin
            next_ir = tap_pkg::OP_IDCODE;
            next_bsr_hold[tap_pkg::OE_CELL] = 1'b1;
        end
        priority case (1'b1) // instruction path wins during an instruction scan
            sel_ir: serial_bit = ir_shift[0];
            sel_bsr: serial_bit = bsr_shift[0];
            sel_id: serial_bit = id_shift[0];
            default: serial_bit = bypass;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            ir_shift <= tap_pkg::OP_IDCODE;
            ir <= tap_pkg::OP_IDCODE;
            bypass <= 1'b0;
            id_shift <= 32'h0000_0000;
            bsr_shift <= '0;
            bsr_hold <= BSR_BITS'(1) << tap_pkg::OE_CELL;
        end else if (clk_en_in) begin
            ir_shift <= next_ir_shift;
            ir <= next_ir;
            bypass <= next_bypass;
            id_shift <= next_id_shift;
            bsr_shift <= next_bsr_shift;
            bsr_hold <= next_bsr_hold;
        end
    end

    // ========================================================
    // serial output, changes only on a falling test clock
    logic next_tdo;
    logic next_tdo_oe_n;
    logic shifting;

    always_comb begin
        shifting = (state == tap_pkg::ST_SH_DR) || (state == tap_pkg::ST_SH_IR);
        next_tdo = tdo_out;
        next_tdo_oe_n = tdo_oe_n_out;
        if (tck_fall) begin
            next_tdo = serial_bit;
            next_tdo_oe_n = ~shifting;
        end
    end

    // power-up keeps the output released
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            tdo_out <= 1'b0;
            tdo_oe_n_out <= 1'b1;
        end else if (clk_en_in) begin
            tdo_out <= next_tdo;
            tdo_oe_n_out <= next_tdo_oe_n;
        end
    end

    // output bus control for external test and sample-z
    assign pins_drive_out = bsr_hold;
    assign extest_out = (ir == tap_pkg::OP_EXTEST);
    assign q_bus_en_out = (ir == tap_pkg::OP_SAMPLE_Z) ? 1'b0 :
                          extest_out ? bsr_hold[tap_pkg::OE_CELL] : 1'b1;

    // ========================================================
    // checks
    // fifth rise in a row with mode select high, from any state
    sequence fifth_high_s;
        clk_en_in && tck_rise && tms_v && (ones_run >= 3'(tap_pkg::RESET_ONES - 1));
    endsequence

    five_high_reset_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        fifth_high_s |=> state == tap_pkg::ST_RESET)
        else $error("five high rises did not reach reset");

    reset_stays_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        (state == tap_pkg::ST_RESET && clk_en_in && tck_rise && tms_v)
        |=> state == tap_pkg::ST_RESET)
        else $error("left reset with mode select high");
    no_rise_hold_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        (clk_en_in && !tck_rise) |=> $stable(state))
        else $error("state moved without test clock rise");
    tdo_on_fall_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        (clk_en_in && !tck_fall) |=> $stable(tdo_out) && $stable(tdo_oe_n_out))
        else $error("serial output changed off a falling edge");
    tdo_hiz_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        (clk_en_in && tck_fall && !shifting) |=> tdo_oe_n_out)
        else $error("serial output driven outside shift");
    ir_idcode_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        (clk_en_in && state == tap_pkg::ST_RESET) |=> ir == tap_pkg::OP_IDCODE)
        else $error("instruction not id after reset");
    ir_capture_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        (clk_en_in && tck_rise && state == tap_pkg::ST_CAP_IR)
        |=> ir_shift[1:0] == tap_pkg::IR_CAPTURE)
        else $error("capture pattern wrong");
    ir_update_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        (clk_en_in && state != tap_pkg::ST_UPD_IR && state != tap_pkg::ST_RESET)
        |=> $stable(ir))
        else $error("instruction changed outside update");
    oe_cell_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        (clk_en_in && state == tap_pkg::ST_RESET) |=> bsr_hold[tap_pkg::OE_CELL])
        else $error("output enable cell not preset");
    id_capture_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        (clk_en_in && tck_rise && state == tap_pkg::ST_CAP_DR && sel_id)
        |=> id_shift == tap_pkg::ID_CODE)
        else $error("id code not captured");
endmodule

// [hdl/tap_pkg.sv]
// constants for the sram boundary-scan test access port
// assumes a 20 mhz core clock that oversamples the external test clock
package tap_pkg;
    // ========================================================
    // instruction register
    localparam int IR_WIDTH = 3;
    localparam logic [2:0] OP_EXTEST = 3'h0;
    localparam logic [2:0] OP_IDCODE = 3'h1;
    localparam logic [2:0] OP_SAMPLE_Z = 3'h2;
    localparam logic [2:0] OP_SAMPLE = 3'h4;
    localparam logic [2:0] OP_BYPASS = 3'h7;
    localparam logic [1:0] IR_CAPTURE = 2'h1;
    // ========================================================
    // data registers
    localparam int ID_WIDTH = 32;
    localparam logic [31:0] ID_CODE = 32'h1234_5679; // value is arbitrary
    localparam int BSR_LEN = 109;
    localparam int OE_CELL = 108;
    localparam int RESET_ONES = 5;
    // ========================================================
    // controller states
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR,
        ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
        ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
    } tap_state_t;
endpackage

// [hdl/tck_sync.sv]
// two-flop synchroniser with rising and falling edge detection
// assumes the input is asynchronous to clk_in
`timescale 1ns/1ps
module tck_sync (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic en_in,
    input wire logic async_in,
    output logic level_out,
    output logic rise_out,
    output logic fall_out
);
    logic meta;
    logic stable;
    logic prev;
    logic next_meta;
    logic next_stable;
    logic next_prev;

    // first flop only feeds the second
    always_comb begin
        next_meta = async_in;
        next_stable = meta;
        next_prev = stable;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta <= 1'b0;
            stable <= 1'b0;
            prev <= 1'b0;
        end else if (en_in) begin
            meta <= next_meta;
            stable <= next_stable;
            prev <= next_prev;
        end
    end

    assign level_out = stable;
    assign rise_out = en_in & stable & ~prev;
    assign fall_out = en_in & ~stable & prev;
endmodule
